// File: common/lapb_pkg.sv
// constants and types shared by the serial link buffer block
// What this block does
// - receiver and transmitter run separately from each other and from register accesses.
// - output bit changes on transmit clock fall; input sampled on receive clock rise.
// - line idles as continuous ones until the first frame has gone out.
// - after first frame or with initiator bit set, flags fill between frames.
// - host lookup tables describe at most eight outstanding packets per direction.
// - one base pointer register gives transmit table segment zero.
// - receive table segment zero sits 40 hex bytes past the transmit base.
// - events set a bit in status register one and raise the interrupt flag.
// - sixteen host registers hold modes, timer, pointer, chain lengths and addresses.
// - loop-back mode routes transmitted stream into the own receiver.
// - loop-back mode clocks the receiver from the transmit bit clock.
// - control field bit 0 clear means an information frame.
// - control bit 0 set, bit 1 clear means a supervisory frame.
// - control bits 0 and 1 both set mean an unnumbered frame.
// - a programmable retry limit bounds retransmissions of one frame.
// - a programmable response timer measures the wait for an answer.
// - frame is flag, address, control, optional info, check sequence, flag.
// - loop select holds request-to-send off and routes it to clear-to-send.
package lapb_pkg;
    localparam int AW = 4;
    localparam int DW = 8;
    // register indices
    localparam logic [3:0] A_CTRL   = 4'h0;
    localparam logic [3:0] A_STAT   = 4'h1;
    localparam logic [3:0] A_LINE   = 4'h2;
    localparam logic [3:0] A_TB_LO  = 4'h3;
    localparam logic [3:0] A_TB_HI  = 4'h4;
    localparam logic [3:0] A_RB_LO  = 4'h5;
    localparam logic [3:0] A_RB_HI  = 4'h6;
    localparam logic [3:0] A_TIMER  = 4'h7;
    localparam logic [3:0] A_RETRY  = 4'h8;
    localparam logic [3:0] A_CHAIN  = 4'h9;
    localparam logic [3:0] A_SEG    = 4'ha;
    localparam logic [3:0] A_TXCTL  = 4'hb;
    localparam logic [3:0] A_RXCTL  = 4'hc;
    localparam logic [3:0] A_RXADR  = 4'hd;
    localparam logic [3:0] A_CMDADR = 4'he;
    localparam logic [3:0] A_RSPADR = 4'hf;
    // field positions
    localparam int C_SEND = 0;
    localparam int C_INIT = 1;
    localparam int C_LOOP = 2;
    localparam int S_RXPKT = 0;
    localparam int S_ACK   = 1;
    localparam int S_ERR   = 2;
    localparam int S_SENT  = 3;
    localparam int NSTAT   = 4;
    // reset values
    localparam logic [7:0]  RST_REG   = 8'h00;
    localparam logic [7:0]  RST_TIMER = 8'h10;
    localparam logic [7:0]  RST_RETRY = 8'h03;
    localparam logic [15:0] RST_BASE  = 16'h0000;
    // link constants
    localparam logic [7:0]  FLAG      = 8'h7e;
    localparam logic [7:0]  UA_MASK   = 8'hef;
    localparam logic [7:0]  UA_CODE   = 8'h63;
    localparam logic [15:0] CRC_INIT  = 16'hffff;
    localparam logic [15:0] CRC_POLY  = 16'h8408;
    localparam logic [15:0] CRC_GOOD  = 16'hf0b8;
    localparam logic [15:0] RX_OFS    = 16'h0040;
    localparam int          SLOTS     = 8;
    // frame classes
    localparam logic [1:0] CL_I = 2'h0;
    localparam logic [1:0] CL_S = 2'h1;
    localparam logic [1:0] CL_U = 2'h3;
    // timing: one response timer tick
    localparam int CLK_PS   = 5000;
    localparam int TICK_NS  = 1000;
    localparam int TICK_CYC = (TICK_NS * 1000) / CLK_PS;
    typedef enum logic [2:0] {
        TX_FILL   = 3'b000,
        TX_OPEN   = 3'b001,
        TX_ADDR   = 3'b011,
        TX_CTRL   = 3'b010,
        TX_FCS_LO = 3'b110,
        TX_FCS_HI = 3'b111,
        TX_CLOSE  = 3'b101
    } tx_state_e;
endpackage : lapb_pkg

// File: rtl/lapb_link_serial_buffer.sv
// serial link side, register bank and response timing of the link controller
module lapb_link_serial_buffer #(
    parameter int TICK_CYCLES = lapb_pkg::TICK_CYC
) (
    // clock and reset
    input  wire logic                     sys_clk,
    input  wire logic                     rst,
    input  wire logic                     clk_en,
    // register port
    input  wire logic [lapb_pkg::AW-1:0]  reg_addr,
    input  wire logic [lapb_pkg::DW-1:0]  reg_wdata,
    input  wire logic                     reg_wr,
    input  wire logic                     reg_rd,
    output logic      [lapb_pkg::DW-1:0]  reg_rdata,
    // serial link pins
    input  wire logic                     tx_bit_clock,
    input  wire logic                     rx_bit_clock,
    input  wire logic                     serial_in,
    input  wire logic                     cts_n,
    output logic                          serial_out,
    output logic                          rts_n,
    output logic                          loop_select,
    // event flag
    output logic                          irq_flag
);
    import lapb_pkg::*;

    // crc-ccitt step, bits taken lsb first
    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
        logic fb;
        fb = c[0] ^ b;
        crc_step = fb ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    endfunction : crc_step

    // pin synchronisers; stage 0 feeds only stage 1
    logic [2:0] tck_s;
    logic [2:0] rck_s;
    logic [1:0] rxd_s;
    logic [1:0] cts_s;
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            tck_s <= '0;
            rck_s <= '0;
            rxd_s <= 2'h3;
            cts_s <= 2'h3;
        end
        else if (clk_en)
        begin
            tck_s <= {tck_s[1:0], tx_bit_clock};
            rck_s <= {rck_s[1:0], rx_bit_clock};
            rxd_s <= {rxd_s[0], serial_in};
            cts_s <= {cts_s[0], cts_n};
        end
    end

    // registers written by software
    logic        init_ff;
    logic        loop_ff;
    logic [15:0] tbase_ff;
    logic [7:0]  timer_ff;
    logic [7:0]  rlim_ff;
    logic [7:0]  chain_ff;
    logic [7:0]  seg_ff;
    logic [7:0]  txctl_ff;
    logic [7:0]  cmdadr_ff;
    logic [7:0]  rspadr_ff;
    logic        send_req;
    assign send_req = reg_wr && reg_addr == A_CTRL && reg_wdata[C_SEND];

    // register writes, independent of both serial paths
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            init_ff   <= 1'b0;
            loop_ff   <= 1'b0;
            tbase_ff  <= RST_BASE;
            timer_ff  <= RST_TIMER;
            rlim_ff   <= RST_RETRY;
            chain_ff  <= RST_REG;
            seg_ff    <= RST_REG;
            txctl_ff  <= RST_REG;
            cmdadr_ff <= RST_REG;
            rspadr_ff <= RST_REG;
        end
        else if (clk_en && reg_wr)
        begin
            unique case (reg_addr)
                A_CTRL:
                begin
                    init_ff <= reg_wdata[C_INIT];
                    loop_ff <= reg_wdata[C_LOOP];
                end
                A_TB_LO:  tbase_ff[7:0]  <= reg_wdata;
                A_TB_HI:  tbase_ff[15:8] <= reg_wdata;
                A_TIMER:  timer_ff  <= reg_wdata;
                A_RETRY:  rlim_ff   <= reg_wdata;
                A_CHAIN:  chain_ff  <= reg_wdata; // count minus one, stored as given
                A_SEG:    seg_ff    <= reg_wdata;
                A_TXCTL:  txctl_ff  <= reg_wdata;
                A_CMDADR: cmdadr_ff <= reg_wdata;
                A_RSPADR: rspadr_ff <= reg_wdata;
                default:  ;
            endcase
        end
    end
    assign loop_select = loop_ff;

    // edges of the bit clocks; loop-back swaps in the transmit clock and line
    logic tx_fall;
    logic tx_rise;
    logic rx_rise;
    logic rx_bit;
    logic out_ff;
    assign tx_fall = tck_s[2] & ~tck_s[1];
    assign tx_rise = ~tck_s[2] & tck_s[1];
    assign rx_rise = loop_ff ? tx_rise : (~rck_s[2] & rck_s[1]);
    assign rx_bit  = loop_ff ? out_ff : rxd_s[1];

    // transmitter state
    tx_state_e  tx_st_ff;
    logic [7:0]  sh_ff;
    logic [2:0]  bit_ff;
    logic [2:0]  ones_ff;
    logic [15:0] crc_ff;
    logic        fill_ff;
    logic        pend_ff;
    logic        rts_ff;
    logic        sent;
    logic        retx;
    logic        cts_ok;
    logic [15:0] crc_n;
    logic        stuff;
    assign crc_n  = crc_step(crc_ff, sh_ff[0]);
    assign stuff  = ones_ff == 3'd5 && tx_st_ff != TX_FILL && tx_st_ff != TX_OPEN;
    // looped clear-to-send follows our own request-to-send
    assign cts_ok = loop_ff ? rts_ff : ~cts_s[1];
    assign sent   = clk_en && tx_fall && tx_st_ff == TX_CLOSE && !stuff && bit_ff == 3'd7;

    // transmit bit engine, stepping on each transmit clock fall
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            tx_st_ff <= TX_FILL;
            sh_ff    <= '0;
            bit_ff   <= '0;
            ones_ff  <= '0;
            crc_ff   <= CRC_INIT;
            fill_ff  <= 1'b0;
            out_ff   <= 1'b1;
            pend_ff  <= 1'b0;
        end
        else if (clk_en)
        begin
            if (tx_fall)
            begin
                if (stuff)
                begin
                    out_ff  <= 1'b0; // inserted zero, byte does not advance
                    ones_ff <= '0;
                end
                else
                begin
                    bit_ff <= bit_ff + 3'd1;
                    unique case (tx_st_ff)
                        TX_FILL:
                        begin
                            out_ff <= (fill_ff || init_ff) ? FLAG[bit_ff] : 1'b1;
                            if (bit_ff == 3'd7 && pend_ff && cts_ok)
                                tx_st_ff <= TX_OPEN;
                        end
                        TX_OPEN:
                        begin
                            out_ff <= FLAG[bit_ff];
                            if (bit_ff == 3'd7)
                            begin
                                tx_st_ff <= TX_ADDR;
                                sh_ff    <= cmdadr_ff;
                                crc_ff   <= CRC_INIT;
                                ones_ff  <= '0;
                                pend_ff  <= 1'b0;
                            end
                        end
                        TX_CLOSE:
                        begin
                            out_ff  <= FLAG[bit_ff];
                            ones_ff <= '0;
                            if (bit_ff == 3'd7)
                            begin
                                tx_st_ff <= TX_FILL;
                                fill_ff  <= 1'b1; // flags from now on
                            end
                        end
                        TX_ADDR, TX_CTRL, TX_FCS_LO, TX_FCS_HI:
                        begin
                            out_ff  <= sh_ff[0];
                            ones_ff <= sh_ff[0] ? ones_ff + 3'd1 : 3'd0;
                            sh_ff   <= sh_ff >> 1;
                            if (tx_st_ff == TX_ADDR || tx_st_ff == TX_CTRL)
                                crc_ff <= crc_n;
                            if (bit_ff == 3'd7)
                            begin
                                unique case (tx_st_ff)
                                    TX_ADDR:
                                    begin
                                        tx_st_ff <= TX_CTRL;
                                        sh_ff    <= txctl_ff;
                                    end
                                    TX_CTRL:
                                    begin
                                        tx_st_ff <= TX_FCS_LO;
                                        sh_ff    <= ~crc_n[7:0];
                                    end
                                    TX_FCS_LO:
                                    begin
                                        tx_st_ff <= TX_FCS_HI;
                                        sh_ff    <= ~crc_ff[15:8];
                                    end
                                    default: tx_st_ff <= TX_CLOSE;
                                endcase
                            end
                        end
                        default: tx_st_ff <= TX_FILL;
                    endcase
                end
            end
            // a new request beats the clear at frame start
            if (send_req || retx)
                pend_ff <= 1'b1;
        end
    end
    assign serial_out = out_ff;

    // request-to-send, held off toward the modem in loop-back
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            rts_ff <= 1'b0;
        else if (clk_en)
            rts_ff <= pend_ff || tx_st_ff != TX_FILL;
    end
    assign rts_n = ~(rts_ff & ~loop_ff);

    // receiver state
    logic [7:0]  raw_ff;
    logic [2:0]  rones_ff;
    logic [6:0]  dly_ff;
    logic [2:0]  dn_ff;
    logic [7:0]  byte_ff;
    logic [2:0]  bc_ff;
    logic [3:0]  nb_ff;
    logic [15:0] rcrc_ff;
    logic [7:0]  radr_ff;
    logic [7:0]  rctl_ff;
    logic        good_ff;
    logic [7:0]  win;
    logic [7:0]  byte_n;
    assign win    = {rx_bit, raw_ff[7:1]};
    assign byte_n = {dly_ff[0], byte_ff[7:1]};

    // receive bit engine: flag hunt, zero removal, 7-bit delay hides flag bits
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            raw_ff   <= '0;
            rones_ff <= '0;
            dly_ff   <= '0;
            dn_ff    <= '0;
            byte_ff  <= '0;
            bc_ff    <= '0;
            nb_ff    <= '0;
            rcrc_ff  <= CRC_INIT;
            radr_ff  <= '0;
            rctl_ff  <= '0;
            good_ff  <= 1'b0;
        end
        else if (clk_en)
        begin
            good_ff <= 1'b0;
            if (rx_rise)
            begin
                raw_ff   <= win;
                rones_ff <= rx_bit ? ((rones_ff == 3'd7) ? rones_ff : rones_ff + 3'd1) : 3'd0;
                if (win == FLAG || (rx_bit && rones_ff >= 3'd6))
                begin
                    // flag closes a frame, abort just drops it
                    good_ff <= win == FLAG && bc_ff == 3'd0 && nb_ff >= 4'd4 && rcrc_ff == CRC_GOOD;
                    dn_ff   <= '0;
                    bc_ff   <= '0;
                    nb_ff   <= '0;
                    rcrc_ff <= CRC_INIT;
                end
                else if (!(rx_bit == 1'b0 && rones_ff == 3'd5))
                begin
                    dly_ff <= {rx_bit, dly_ff[6:1]};
                    if (dn_ff != 3'd7)
                        dn_ff <= dn_ff + 3'd1;
                    else
                    begin
                        byte_ff <= byte_n;
                        bc_ff   <= bc_ff + 3'd1;
                        rcrc_ff <= crc_step(rcrc_ff, dly_ff[0]);
                        if (bc_ff == 3'd7)
                        begin
                            if (nb_ff != 4'hf)
                                nb_ff <= nb_ff + 4'd1;
                            if (nb_ff == 4'd0)
                                radr_ff <= byte_n;
                            if (nb_ff == 4'd1)
                                rctl_ff <= byte_n;
                        end
                    end
                end
            end
        end
    end

    // frame classifier
    logic [1:0] cls;
    logic [1:0] cls_ff;
    logic       for_us;
    assign cls    = !rctl_ff[0] ? CL_I : (rctl_ff[1] ? CL_U : CL_S);
    assign for_us = radr_ff == cmdadr_ff || radr_ff == rspadr_ff;
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            cls_ff <= CL_I;
        else if (clk_en && good_ff)
            cls_ff <= cls;
    end

    // response timer and retry count
    logic        wait_ff;
    logic [7:0]  tmr_ff;
    logic [15:0] pre_ff;
    logic [7:0]  rcnt_ff;
    logic        tick;
    logic        expire;
    logic        ack;
    logic        give_up;
    assign tick    = pre_ff == 16'(TICK_CYCLES - 1);
    assign expire  = clk_en && wait_ff && tick && tmr_ff == '0;
    assign ack     = clk_en && good_ff && for_us && wait_ff
                     && (cls == CL_S || (rctl_ff & UA_MASK) == UA_CODE);
    assign give_up = expire && rcnt_ff == rlim_ff;
    assign retx    = expire && !give_up;
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            wait_ff <= 1'b0;
            tmr_ff  <= '0;
            pre_ff  <= '0;
            rcnt_ff <= '0;
        end
        else if (clk_en)
        begin
            pre_ff <= (tick || !wait_ff) ? 16'h0000 : pre_ff + 16'h0001;
            if (wait_ff && tick && tmr_ff != '0)
                tmr_ff <= tmr_ff - 8'h01;
            if (ack || give_up)
            begin
                wait_ff <= 1'b0;
                rcnt_ff <= '0;
            end
            else if (retx)
            begin
                wait_ff <= 1'b0;
                rcnt_ff <= rcnt_ff + 8'h01;
            end
            else if (sent)
            begin
                wait_ff <= 1'b1;
                tmr_ff  <= timer_ff;
            end
        end
    end

    // sticky events; a read clears them but a same-cycle event survives
    logic [NSTAT-1:0] stat_ff;
    logic [NSTAT-1:0] ev;
    always_comb
    begin
        ev          = '0;
        ev[S_RXPKT] = clk_en && good_ff && for_us && cls == CL_I;
        ev[S_ACK]   = ack;
        ev[S_ERR]   = give_up;
        ev[S_SENT]  = sent;
    end
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            stat_ff <= '0;
        else if (clk_en)
            stat_ff <= ((reg_rd && reg_addr == A_STAT) ? '0 : stat_ff) | ev;
    end
    assign irq_flag = |stat_ff;

    // read mux; data stands only in the cycle after the strobe
    logic [15:0] rbase;
    // transmit table spans the eight packet slots before the receive table
    assign rbase = tbase_ff + RX_OFS;
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            reg_rdata <= '0;
        else if (clk_en)
        begin
            reg_rdata <= '0;
            if (reg_rd)
            begin
                unique case (reg_addr)
                    A_CTRL:   reg_rdata <= {5'h00, loop_ff, init_ff, 1'b0};
                    A_STAT:   reg_rdata <= {4'h0, stat_ff};
                    A_LINE:   reg_rdata <= {rcnt_ff[3:0], fill_ff, wait_ff, cls_ff};
                    A_TB_LO:  reg_rdata <= tbase_ff[7:0];
                    A_TB_HI:  reg_rdata <= tbase_ff[15:8];
                    A_RB_LO:  reg_rdata <= rbase[7:0];
                    A_RB_HI:  reg_rdata <= rbase[15:8];
                    A_TIMER:  reg_rdata <= timer_ff;
                    A_RETRY:  reg_rdata <= rlim_ff;
                    A_CHAIN:  reg_rdata <= chain_ff;
                    A_SEG:    reg_rdata <= seg_ff;
                    A_TXCTL:  reg_rdata <= txctl_ff;
                    A_RXCTL:  reg_rdata <= rctl_ff;
                    A_RXADR:  reg_rdata <= radr_ff;
                    A_CMDADR: reg_rdata <= cmdadr_ff;
                    A_RSPADR: reg_rdata <= rspadr_ff;
                endcase
            end
        end
    end

    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence s_rb_read;
        reg_rd && reg_addr == A_RB_LO;
    endsequence
    sequence s_giveup;
        give_up;
    endsequence
    AST_OUT_ON_FALL: assert property ($changed(serial_out) |-> $past(tx_fall))
        else $error("serial output moved without a transmit clock fall");
    AST_IDLE_ONES: assert property (tx_st_ff == TX_FILL && !fill_ff && !init_ff && $past(tx_fall)
                                    && $past(tx_st_ff == TX_FILL) |-> serial_out)
        else $error("line not idle ones before first frame");
    AST_FILL_KEPT: assert property (fill_ff |=> fill_ff)
        else $error("flag fill dropped after first frame");
    AST_RX_BASE: assert property (s_rb_read |=> reg_rdata == $past(tbase_ff[7:0]) + 8'h40)
        else $error("receive table base wrong");
    AST_EVENT_FLAG: assert property (|ev && clk_en |=> irq_flag && (stat_ff & $past(ev)) == $past(ev))
        else $error("event lost from status");
    AST_LOOP_RTS: assert property (loop_select |-> rts_n)
        else $error("request-to-send active toward modem in loop-back");
    AST_CLASS: assert property (good_ff && clk_en |=> cls_ff == (!$past(rctl_ff[0]) ? CL_I
                                : ($past(rctl_ff[1]) ? CL_U : CL_S)))
        else $error("frame class wrong");
    AST_GIVE_UP: assert property (s_giveup |=> !wait_ff && stat_ff[S_ERR] && rcnt_ff == 8'h00)
        else $error("retry limit not honoured");
    AST_RETX: assert property (retx |=> pend_ff && rcnt_ff == $past(rcnt_ff) + 8'h01)
        else $error("expiry did not retransmit");
    AST_TIMER_LOAD: assert property (sent |=> wait_ff && tmr_ff == $past(timer_ff))
        else $error("response timer not started");
endmodule : lapb_link_serial_buffer

// File: tb/lapb_modem_model.sv
// modem side model: bit clocks, line echo and clear-to-send
module lapb_modem_model (
    // link pins
    output logic      tx_bit_clock,
    output logic      rx_bit_clock,
    output logic      serial_in,
    output logic      cts_n,
    input  wire logic serial_out,
    input  wire logic rts_n,
    // bench control
    input  wire logic ext_loop
);
    timeunit 1ns;
    timeprecision 1ps;
    logic junk_ff = 1'b0;
    // line is never silent, so the bit clock runs free
    initial tx_bit_clock = 1'b0;
    always #32 tx_bit_clock = ~tx_bit_clock;
    // a released line toggles so stale data never looks valid
    always @(negedge tx_bit_clock) junk_ff <= ~junk_ff;
    // external echo with receive clock taken from transmit clock
    assign rx_bit_clock = ext_loop & tx_bit_clock;
    assign serial_in = ext_loop ? serial_out : junk_ff;
    assign cts_n = rts_n;
endmodule : lapb_modem_model

// File: tb/test_lapb_link_serial_buffer.sv
// self-checking bench for the serial link buffer block
module test_lapb_link_serial_buffer;
    timeunit 1ns;
    timeprecision 1ps;
    import lapb_pkg::*;
    logic       sys_clk = 1'b0;
    logic       rst = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_wr = 1'b0;
    logic       reg_rd = 1'b0;
    logic       ext_loop = 1'b1;
    logic [7:0] reg_rdata, rdv, acc;
    logic       tx_bit_clock, rx_bit_clock, serial_in, cts_n, serial_out, rts_n, loop_select, irq_flag, z, ck;
    int         errors = 0;
    int         n_compared = 0;
    always #2.5 sys_clk = ~sys_clk;
    // short tick keeps response waits brief
    lapb_link_serial_buffer #(.TICK_CYCLES(4)) i_dut (.sys_clk(sys_clk), .rst(rst), .clk_en(1'b1),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .tx_bit_clock(tx_bit_clock), .rx_bit_clock(rx_bit_clock), .serial_in(serial_in), .cts_n(cts_n),
        .serial_out(serial_out), .rts_n(rts_n), .loop_select(loop_select), .irq_flag(irq_flag));
    lapb_modem_model i_modem (.tx_bit_clock(tx_bit_clock), .rx_bit_clock(rx_bit_clock), .serial_in(serial_in),
        .cts_n(cts_n), .serial_out(serial_out), .rts_n(rts_n), .ext_loop(ext_loop));
    task automatic report_and_stop;
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : report_and_stop
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr
    // data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd
    // status clears on read, so bits are gathered over polls
    task automatic wait_stat(input logic [7:0] m);
        acc = 8'h00;
        for (int i = 0; i < 3000 && (acc & m) != m; i++)
        begin
            rd(A_STAT, rdv);
            acc = acc | rdv;
        end
        if ((acc & m) != m)
        begin
            errors++;
            report_and_stop();
        end
    endtask : wait_stat
    // watch the line for a zero; note the bit clock when it first appears
    task automatic see_zero;
        z = 1'b0;
        for (int i = 0; i < 400; i++)
        begin
            @(posedge sys_clk);
            if (serial_out === 1'b0 && z === 1'b0)
            begin
                z = 1'b1;
                ck = tx_bit_clock;
            end
        end
    endtask : see_zero
    task automatic s_frame(input logic [7:0] c, input logic [7:0] ctl, input logic [7:0] m, input logic [1:0] cl);
        wr(A_TXCTL, c);
        wr(A_CTRL, ctl);
        wait_stat(m);
        chk("status", acc & m, m);
        // expiry can beat the looped frame's closing flag, so let the class land
        repeat (40) @(posedge sys_clk);
        rd(A_LINE, rdv);
        chk("class", {6'h00, rdv[1:0]}, {6'h00, cl});
    endtask : s_frame
    logic [3:0] ad [6] = '{A_TB_LO, A_TB_HI, A_CHAIN, A_SEG, A_CMDADR, A_RSPADR};
    logic [7:0] vl [6] = '{8'h00, 8'h08, 8'h04, 8'h03, 8'h5a, 8'h5a};
    initial
    begin
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        rd(A_TIMER, rdv);
        chk("timer", rdv, RST_TIMER);
        rd(A_RETRY, rdv);
        chk("retry", rdv, RST_RETRY);
        see_zero();
        chk("idle", {7'h00, z}, 8'h00);
        wr(A_CTRL, 8'h02);
        see_zero();
        chk("fill", {7'h00, z}, 8'h01);
        chk("edge", {7'h00, ck}, 8'h00);
        foreach (ad[i]) wr(ad[i], vl[i]);
        wr(A_RB_LO, 8'hff);
        foreach (ad[i])
        begin
            rd(ad[i], rdv);
            chk("reg", rdv, vl[i]);
        end
        rd(A_RB_LO, rdv);
        chk("rxlo", rdv, 8'h40);
        rd(A_RB_HI, rdv);
        chk("rxhi", rdv, 8'h08);
        wr(A_TIMER, 8'hff);
        s_frame(8'h01, 8'h03, 8'h0a, CL_S);
        chk("irq", {7'h00, irq_flag}, 8'h00);
        ext_loop <= 1'b0;
        wr(A_CTRL, 8'h06);
        // the write lands at this edge; look once it has settled
        #1;
        chk("loop", {7'h00, loop_select}, 8'h01);
        chk("rts", {7'h00, rts_n}, 8'h01);
        s_frame(8'h01, 8'h07, 8'h0a, CL_S);
        ext_loop <= 1'b1;
        wr(A_CTRL, 8'h02);
        wr(A_TIMER, 8'h00);
        wr(A_RETRY, 8'h00);
        s_frame(8'h00, 8'h03, 8'h05, CL_I);
        s_frame(8'h03, 8'h03, 8'h0c, CL_U);
        report_and_stop();
    end
endmodule : test_lapb_link_serial_buffer
